// ==== hdl/packet_protocol_filter_regs.sv ====
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module packet_protocol_filter_regs #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // ahb-lite register bus
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // packet engine status in
    input wire logic rxMode,
    input wire logic pktCheck,
    input wire logic [7:0] pktSource,
    input wire logic [7:0] pktDest,
    input wire logic crcOk,
    input wire logic ackRequested,
    // receive timeout sources
    input wire logic carrierSense,
    input wire logic sync_quality_indicator,
    input wire logic preamble_quality_indicator,
    // wake-up timer events
    input wire logic wakeupStart,
    input wire logic wakeupReloadReq,
    // protocol settings out
    output logic [3:0] max_retransmit_count,
    output logic retransmitEnable,
    output logic suppress_ack_request,
    output logic persistent_receive,
    output logic ackReply,
    // fifo levels out
    output logic [6:0] rx_almost_full_level,
    output logic [6:0] rx_almost_empty_level,
    output logic [6:0] tx_almost_full_level,
    output logic [6:0] tx_almost_empty_level,
    // filtering out
    output logic pktAccept,
    output logic pktDecided,
    output logic dualSyncActive,
    output logic [31:0] secondarySyncWord,
    output logic [7:0] txDestAddr,
    output logic [7:0] txSourceAddr,
    // timers out
    output logic rxTimeoutStop,
    output logic [7:0] rx_timeout_count,
    output logic [7:0] rx_timeout_prescale,
    output logic wakeupLoad,
    output logic [7:0] wakeupLoadPrescale,
    output logic [7:0] wakeupLoadCount,
    // back-off seed out
    output logic [14:0] backoff_random_seed
);
    logic [7:0] regVal [pkt_filter_pkg::NUM_REGS];
    logic regWr;
    logic [7:0] regIdx;
    logic [7:0] regWrData;
    logic [7:0] rdData;

    // decoded configuration
    logic secSyncSel;
    logic autoFilter;
    logic reloadMode;
    logic autoAck;
    logic tmoOrSel;
    logic srcFltEn;
    logic bcastFltEn;
    logic mcastFltEn;
    logic ownFltEn;
    logic crcFltEn;
    logic [7:0] srcMask;
    logic [7:0] goal3;
    logic [7:0] goal2;
    logic [7:0] goal1;
    logic [7:0] goal0;

    // filter decision terms
    logic dualSync;
    logic srcOk;
    logic anyDestEn;
    logic destHit;
    logic crcPass;
    logic accept;
    logic timeoutStop;

    // registered outputs
    logic ackReply_ff;
    logic pktAccept_ff;
    logic pktDecided_ff;
    logic dualSync_ff;
    logic [31:0] syncWord_ff;
    logic [7:0] txDest_ff;
    logic [7:0] txSrc_ff;
    logic rxTimeoutStop_ff;
    logic wakeupLoad_ff;
    logic [7:0] wuPre_ff;
    logic [7:0] wuCnt_ff;

    if (ADDR_W < 10) begin : g_addr_check
        $error("packet_protocol_filter_regs: ADDR_W below 10");
    end

    ahb_reg_slave #(
        .ADDR_W(ADDR_W)
    ) u_ahb_reg_slave (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wrEn(regWr),
        .regIdx(regIdx),
        .wrData(regWrData),
        .rdData(rdData)
    );

    // one storage cell per register; writes to unmapped indices fall through
    genvar gi;
    generate
        for (gi = 0; gi < pkt_filter_pkg::NUM_REGS; gi++) begin : g_reg
            cfg_reg #(
                .WIDTH(pkt_filter_pkg::DATA_W),
                .RST(pkt_filter_pkg::REG_RST[gi]),
                .MASK(pkt_filter_pkg::REG_MASK[gi])
            ) u_cfg_reg (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .wrEn(regWr && (regIdx == pkt_filter_pkg::REG_IDX[gi])),
                .wrData(regWrData),
                .value(regVal[gi])
            );
        end
    endgenerate

    // unmapped indices read zero
    always_comb begin
        rdData = 8'h00;
        for (int i = 0; i < pkt_filter_pkg::NUM_REGS; i++) begin
            if (regIdx == pkt_filter_pkg::REG_IDX[i]) begin
                rdData = regVal[i];
            end
        end
    end

    // field decode
    assign secSyncSel = regVal[pkt_filter_pkg::S_PKT_CTRL][pkt_filter_pkg::B_SEC_SYNC];
    assign autoFilter = regVal[pkt_filter_pkg::S_PROTO_CTRL][pkt_filter_pkg::B_AUTO_FLT];
    assign reloadMode = regVal[pkt_filter_pkg::S_PROTO_CTRL][pkt_filter_pkg::B_RELOAD_MODE];
    assign autoAck = regVal[pkt_filter_pkg::S_RETX_ACK][pkt_filter_pkg::B_AUTO_ACK];
    assign tmoOrSel = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_TMO_OR];
    assign srcFltEn = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_SRC_FLT];
    assign bcastFltEn = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_BCAST_FLT];
    assign mcastFltEn = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_MCAST_FLT];
    assign ownFltEn = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_OWN_FLT];
    assign crcFltEn = regVal[pkt_filter_pkg::S_FLT_OPT][pkt_filter_pkg::B_CHECKSUM_FILTER_ENABLE];
    assign srcMask = regVal[pkt_filter_pkg::S_SRC_MASK];
    assign goal3 = regVal[pkt_filter_pkg::S_GOAL3];
    assign goal2 = regVal[pkt_filter_pkg::S_GOAL2];
    assign goal1 = regVal[pkt_filter_pkg::S_GOAL1];
    assign goal0 = regVal[pkt_filter_pkg::S_GOAL0];

    // protocol controls
    assign max_retransmit_count =
        regVal[pkt_filter_pkg::S_RETX_ACK][pkt_filter_pkg::B_RETX_HI:pkt_filter_pkg::B_RETX_LO];
    assign retransmitEnable = (max_retransmit_count != 4'h0);
    assign suppress_ack_request =
        regVal[pkt_filter_pkg::S_RETX_ACK][pkt_filter_pkg::B_NACK];
    assign persistent_receive =
        regVal[pkt_filter_pkg::S_RETX_ACK][pkt_filter_pkg::B_PERSISTENT_RECEIVE];

    // fifo thresholds
    assign rx_almost_full_level =
        regVal[pkt_filter_pkg::S_RX_FULL][pkt_filter_pkg::LEVEL_W-1:0];
    assign rx_almost_empty_level =
        regVal[pkt_filter_pkg::S_RX_EMPTY][pkt_filter_pkg::LEVEL_W-1:0];
    assign tx_almost_full_level =
        regVal[pkt_filter_pkg::S_TX_FULL][pkt_filter_pkg::LEVEL_W-1:0];
    assign tx_almost_empty_level =
        regVal[pkt_filter_pkg::S_TX_EMPTY][pkt_filter_pkg::LEVEL_W-1:0];

    // timer settings pass straight through
    assign rx_timeout_count = regVal[pkt_filter_pkg::S_RXT_CNT];
    assign rx_timeout_prescale = regVal[pkt_filter_pkg::S_RXT_PRE];
    assign backoff_random_seed = {regVal[pkt_filter_pkg::S_SEED_HI][6:0],
        regVal[pkt_filter_pkg::S_SEED_LO]};

    // dual sync only while receiving; in transmit the select picks a sync word elsewhere
    assign dualSync = secSyncSel && rxMode;

    // source compare ignores bits the mask clears
    assign srcOk = !srcFltEn || (((pktSource ^ goal3) & srcMask) == 8'h00);

    // destination filters are alternatives; any enabled match accepts
    assign anyDestEn = bcastFltEn || mcastFltEn || ownFltEn;
    always_comb begin
        destHit = 1'b0;
        if (bcastFltEn && pktDest == goal2) begin
            destHit = 1'b1;
        end
        if (mcastFltEn && pktDest == goal1) begin
            destHit = 1'b1;
        end
        if (ownFltEn && pktDest == goal0) begin
            destHit = 1'b1;
        end
    end

    assign crcPass = !crcFltEn || crcOk;

    // address bytes are sync bytes in dual sync mode, so address checks stand down
    always_comb begin
        accept = 1'b1;
        if (autoFilter) begin
            accept = crcPass;
            if (!dualSync) begin
                accept = crcPass && srcOk && (!anyDestEn || destHit);
            end
        end
    end

    assign timeoutStop = tmoOrSel ?
        (carrierSense || sync_quality_indicator || preamble_quality_indicator) :
        (carrierSense && sync_quality_indicator && preamble_quality_indicator);

    // filter verdict, one pulse per checked packet
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pktAccept_ff <= 1'b0;
            pktDecided_ff <= 1'b0;
        end else begin
            pktDecided_ff <= pktCheck;
            if (pktCheck) begin
                pktAccept_ff <= accept;
            end
        end
    end

    // ack answer only for packets that asked and survived filtering
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ackReply_ff <= 1'b0;
        end else begin
            ackReply_ff <= pktCheck && ackRequested && autoAck && accept;
        end
    end

    // goal bytes as addresses or secondary sync word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dualSync_ff <= 1'b0;
            syncWord_ff <= 32'h0000_0000;
            txDest_ff <= 8'h00;
            txSrc_ff <= 8'h00;
        end else begin
            dualSync_ff <= dualSync;
            syncWord_ff <= dualSync ? {goal3, goal2, goal1, goal0} : 32'h0000_0000;
            txDest_ff <= goal3;
            txSrc_ff <= goal0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rxTimeoutStop_ff <= 1'b0;
        end else begin
            rxTimeoutStop_ff <= timeoutStop;
        end
    end

    // start loads the timer pair unless a reload in reload mode comes in the same cycle and wins; a reload event outside reload mode is dropped
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wakeupLoad_ff <= 1'b0;
            wuPre_ff <= 8'h00;
            wuCnt_ff <= 8'h00;
        end else begin
            wakeupLoad_ff <= 1'b0;
            if (wakeupReloadReq && reloadMode) begin
                wakeupLoad_ff <= 1'b1;
                wuPre_ff <= regVal[pkt_filter_pkg::S_WU_RL_PRE];
                wuCnt_ff <= regVal[pkt_filter_pkg::S_WU_RL_CNT];
            end else if (wakeupStart) begin
                wakeupLoad_ff <= 1'b1;
                wuPre_ff <= regVal[pkt_filter_pkg::S_WU_PRE];
                wuCnt_ff <= regVal[pkt_filter_pkg::S_WU_CNT];
            end
        end
    end

    assign ackReply = ackReply_ff;
    assign pktAccept = pktAccept_ff;
    assign pktDecided = pktDecided_ff;
    assign dualSyncActive = dualSync_ff;
    assign secondarySyncWord = syncWord_ff;
    assign txDestAddr = txDest_ff;
    assign txSourceAddr = txSrc_ff;
    assign rxTimeoutStop = rxTimeoutStop_ff;
    assign wakeupLoad = wakeupLoad_ff;
    assign wakeupLoadPrescale = wuPre_ff;
    assign wakeupLoadCount = wuCnt_ff;
endmodule

// ==== include/pkt_filter_pkg.sv ====
package pkt_filter_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PKT_CTRL = 8'h30;
    localparam logic [7:0] IDX_PROTO_CTRL = 8'h3a;
    localparam logic [7:0] IDX_RETX_ACK = 8'h3b;
    localparam logic [7:0] IDX_RX_FULL = 8'h3c;
    localparam logic [7:0] IDX_RX_EMPTY = 8'h3d;
    localparam logic [7:0] IDX_TX_FULL = 8'h3e;
    localparam logic [7:0] IDX_TX_EMPTY = 8'h3f;
    localparam logic [7:0] IDX_FLT_OPT = 8'h40;
    localparam logic [7:0] IDX_SRC_MASK = 8'h41;
    localparam logic [7:0] IDX_GOAL3 = 8'h42;
    localparam logic [7:0] IDX_GOAL2 = 8'h43;
    localparam logic [7:0] IDX_GOAL1 = 8'h44;
    localparam logic [7:0] IDX_GOAL0 = 8'h45;
    localparam logic [7:0] IDX_RXT_CNT = 8'h46;
    localparam logic [7:0] IDX_RXT_PRE = 8'h47;
    localparam logic [7:0] IDX_WU_PRE = 8'h48;
    localparam logic [7:0] IDX_WU_CNT = 8'h49;
    localparam logic [7:0] IDX_WU_RL_PRE = 8'h4a;
    localparam logic [7:0] IDX_WU_RL_CNT = 8'h4b;
    localparam logic [7:0] IDX_SEED_HI = 8'h4c;
    localparam logic [7:0] IDX_SEED_LO = 8'h4d;

    localparam int NUM_REGS = 21;
    localparam int DATA_W = 8;

    // slot of each register in the bank
    localparam int S_PKT_CTRL = 0;
    localparam int S_PROTO_CTRL = 1;
    localparam int S_RETX_ACK = 2;
    localparam int S_RX_FULL = 3;
    localparam int S_RX_EMPTY = 4;
    localparam int S_TX_FULL = 5;
    localparam int S_TX_EMPTY = 6;
    localparam int S_FLT_OPT = 7;
    localparam int S_SRC_MASK = 8;
    localparam int S_GOAL3 = 9;
    localparam int S_GOAL2 = 10;
    localparam int S_GOAL1 = 11;
    localparam int S_GOAL0 = 12;
    localparam int S_RXT_CNT = 13;
    localparam int S_RXT_PRE = 14;
    localparam int S_WU_PRE = 15;
    localparam int S_WU_CNT = 16;
    localparam int S_WU_RL_PRE = 17;
    localparam int S_WU_RL_CNT = 18;
    localparam int S_SEED_HI = 19;
    localparam int S_SEED_LO = 20;

    localparam logic [7:0] REG_IDX [NUM_REGS] = '{
        IDX_PKT_CTRL, IDX_PROTO_CTRL, IDX_RETX_ACK, IDX_RX_FULL, IDX_RX_EMPTY,
        IDX_TX_FULL, IDX_TX_EMPTY, IDX_FLT_OPT, IDX_SRC_MASK, IDX_GOAL3,
        IDX_GOAL2, IDX_GOAL1, IDX_GOAL0, IDX_RXT_CNT, IDX_RXT_PRE, IDX_WU_PRE,
        IDX_WU_CNT, IDX_WU_RL_PRE, IDX_WU_RL_CNT, IDX_SEED_HI, IDX_SEED_LO};
    localparam logic [7:0] REG_RST [NUM_REGS] = '{
        8'h00, 8'h00, 8'h08, 8'h30, 8'h30, 8'h30, 8'h30, 8'h40, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h4c,
        8'h00};
    // writable bits; the rest are reserved and read zero
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'h02, 8'h41, 8'hfe, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h5f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f,
        8'hff};

    // field positions
    localparam int B_SEC_SYNC = 1;
    localparam int B_AUTO_FLT = 0;
    localparam int B_RELOAD_MODE = 6;
    localparam int B_RETX_HI = 7;
    localparam int B_RETX_LO = 4;
    localparam int B_NACK = 3;
    localparam int B_AUTO_ACK = 2;
    localparam int B_PERSISTENT_RECEIVE = 1;
    localparam int B_TMO_OR = 6;
    localparam int B_SRC_FLT = 4;
    localparam int B_BCAST_FLT = 3;
    localparam int B_MCAST_FLT = 2;
    localparam int B_OWN_FLT = 1;
    localparam int B_CHECKSUM_FILTER_ENABLE = 0;
    localparam int LEVEL_W = 7;
    localparam int SEED_W = 15;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RD_WAIT = 2'b01,
        BUS_RD_DONE = 2'b11,
        BUS_WR = 2'b10
    } bus_state_t;
endpackage

// ==== hdl/cfg_reg.sv ====
`timescale 1ns/1ps
module cfg_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST = '0,
    parameter logic [WIDTH-1:0] MASK = '1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // write port
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    // stored value, reserved bits zero
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] value_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            value_ff <= RST & MASK;
        end else if (wrEn) begin
            value_ff <= wrData & MASK;
        end
    end

    assign value = value_ff;
endmodule

// ==== hdl/ahb_reg_slave.sv ====
`timescale 1ns/1ps
module ahb_reg_slave #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // ahb-lite
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output logic wrEn,
    output logic [7:0] regIdx,
    output logic [7:0] wrData,
    input wire logic [7:0] rdData
);
    pkt_filter_pkg::bus_state_t state_ff;
    pkt_filter_pkg::bus_state_t nxt_state;
    logic [7:0] idx_ff;
    logic [31:0] hrdata_ff;
    logic take;

    if (ADDR_W < 10) begin : g_addr_check
        $error("ahb_reg_slave: ADDR_W below 10");
    end

    // only word transfers are defined; other sizes are served as words
    assign take = hsel && hready && htrans[1];

    always_comb begin
        nxt_state = pkt_filter_pkg::BUS_IDLE;
        if (state_ff == pkt_filter_pkg::BUS_RD_WAIT) begin
            nxt_state = pkt_filter_pkg::BUS_RD_DONE;
        end else if (take) begin
            nxt_state = hwrite ? pkt_filter_pkg::BUS_WR : pkt_filter_pkg::BUS_RD_WAIT;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= pkt_filter_pkg::BUS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idx_ff <= 8'h00;
        end else if (take && state_ff != pkt_filter_pkg::BUS_RD_WAIT) begin
            idx_ff <= haddr[9:2];
        end
    end

    // one wait state on reads so read data leaves a flip-flop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (state_ff == pkt_filter_pkg::BUS_RD_WAIT) begin
            hrdata_ff <= {24'h00_0000, rdData};
        end
    end

    assign hreadyout = (state_ff != pkt_filter_pkg::BUS_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign wrEn = (state_ff == pkt_filter_pkg::BUS_WR);
    assign regIdx = idx_ff;
    assign wrData = hwdata[7:0];
endmodule

// ==== verif/packet_protocol_filter_regs_asserts.sv ====
`timescale 1ns/1ps
module packet_protocol_filter_regs_asserts (
    // clock and reset
    input logic sys_clk,
    input logic nrst,
    // bus
    input logic hreadyout,
    input logic hresp,
    // packet check
    input logic pktCheck,
    input logic pktDecided,
    input logic pktAccept,
    input logic ackReply,
    // timeout sources and stop, dual sync
    input logic carrierSense,
    input logic sync_quality_indicator,
    input logic preamble_quality_indicator,
    input logic rxTimeoutStop,
    input logic rxMode,
    input logic dualSyncActive,
    // wake-up
    input logic wakeupStart,
    input logic wakeupReloadReq,
    input logic wakeupLoad,
    input logic [7:0] wakeupLoadPrescale,
    // protocol
    input logic [3:0] max_retransmit_count,
    input logic retransmitEnable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_OKAY: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
        else $error("long wait state");
    AST_RETX_EN: assert property (retransmitEnable == (max_retransmit_count != 4'h0))
        else $error("retx enable wrong");
    AST_DECIDED: assert property (pktDecided == $past(pktCheck))
        else $error("late decision");
    AST_ACCEPT_HOLD: assert property (!$past(pktCheck) |-> $stable(pktAccept))
        else $error("accept moved");
    AST_ACK: assert property (ackReply |-> $past(pktCheck) && pktAccept)
        else $error("ack without accept");
    AST_TMO_ALL: assert property (carrierSense && sync_quality_indicator &&
        preamble_quality_indicator |=> rxTimeoutStop)
        else $error("timeout not stopped");
    AST_TMO_NONE: assert property (!carrierSense && !sync_quality_indicator &&
        !preamble_quality_indicator |=> !rxTimeoutStop)
        else $error("timeout stopped");
    AST_DUAL_RX: assert property (!$past(rxMode) |-> !dualSyncActive)
        else $error("dual sync outside rx");
    AST_LOAD_CAUSE: assert property (wakeupLoad |-> $past(wakeupStart || wakeupReloadReq))
        else $error("load without event");
    AST_LOAD_HOLD: assert property (!wakeupLoad |-> $stable(wakeupLoadPrescale))
        else $error("load values moved");
endmodule

// ==== verif/test_packet_protocol_filter_regs.sv ====
`timescale 1ns/1ps
module test_packet_protocol_filter_regs;
    // bus
    logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp;
    logic [9:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    // stimulus
    logic rxMode, pktCheck, crcOk, ackRequested, carrierSense, wakeupStart, wakeupReloadReq;
    logic sync_quality_indicator, preamble_quality_indicator;
    logic [7:0] pktSource, pktDest;
    // observed
    logic [3:0] max_retransmit_count;
    logic retransmitEnable, suppress_ack_request, persistent_receive, ackReply;
    logic [6:0] rx_almost_full_level, rx_almost_empty_level;
    logic [6:0] tx_almost_full_level, tx_almost_empty_level;
    logic pktAccept, pktDecided, dualSyncActive, rxTimeoutStop, wakeupLoad;
    logic [31:0] secondarySyncWord;
    logic [7:0] txDestAddr, txSourceAddr, rx_timeout_count, rx_timeout_prescale;
    logic [7:0] wakeupLoadPrescale, wakeupLoadCount;
    logic [14:0] backoff_random_seed;
    int badCount, cmpCount, cyc;

    packet_protocol_filter_regs u_packet_protocol_filter_regs (
        .hsize(3'h2), .hready(hreadyout), .*);

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            badCount++;
            finishTest();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wt;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        wt();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wt();
        rd = hrdata;
    endtask

    task automatic t_regs;
        logic [7:0] idx, m;
        @(negedge sys_clk);
        chk(rx_almost_full_level, 7'h30);
        chk(rx_timeout_count, 8'h01);
        chk(backoff_random_seed, {7'h4c, 8'h00});
        for (int i = 0; i < pkt_filter_pkg::NUM_REGS; i++) begin
            bus(pkt_filter_pkg::REG_IDX[i], 1'b0, 8'h00);
            chk(rd, {24'h0, pkt_filter_pkg::REG_RST[i]});
        end
        // last pass hits an unmapped index
        for (int i = 0; i <= pkt_filter_pkg::NUM_REGS; i++) begin
            idx = 8'h50;
            m = 8'h00;
            if (i < pkt_filter_pkg::NUM_REGS) begin
                idx = pkt_filter_pkg::REG_IDX[i];
                m = pkt_filter_pkg::REG_MASK[i];
            end
            bus(idx, 1'b1, 8'hff);
            bus(idx, 1'b0, 8'h00);
            chk(rd, {24'h0, m});
            bus(idx, 1'b1, 8'h00);
            bus(idx, 1'b0, 8'h00);
            chk(rd, 32'h0);
        end
        $display("register test done");
    endtask

    task automatic t_fields;
        bus(pkt_filter_pkg::IDX_RETX_ACK, 1'b1, 8'hf6);
        @(negedge sys_clk);
        chk(max_retransmit_count, 4'hf);
        chk(retransmitEnable, 1'b1);
        chk(persistent_receive, 1'b1);
        chk(suppress_ack_request, 1'b0);
        bus(pkt_filter_pkg::IDX_RETX_ACK, 1'b1, 8'h08);
        bus(pkt_filter_pkg::IDX_RX_FULL, 1'b1, 8'h11);
        bus(pkt_filter_pkg::IDX_RX_EMPTY, 1'b1, 8'h22);
        bus(pkt_filter_pkg::IDX_TX_FULL, 1'b1, 8'h33);
        bus(pkt_filter_pkg::IDX_TX_EMPTY, 1'b1, 8'h44);
        bus(pkt_filter_pkg::IDX_RXT_CNT, 1'b1, 8'h5a);
        bus(pkt_filter_pkg::IDX_RXT_PRE, 1'b1, 8'ha5);
        bus(pkt_filter_pkg::IDX_SEED_HI, 1'b1, 8'h2b);
        bus(pkt_filter_pkg::IDX_SEED_LO, 1'b1, 8'hc3);
        @(negedge sys_clk);
        chk(retransmitEnable, 1'b0);
        chk(suppress_ack_request, 1'b1);
        chk(rx_almost_full_level, 7'h11);
        chk(rx_almost_empty_level, 7'h22);
        chk(tx_almost_full_level, 7'h33);
        chk(tx_almost_empty_level, 7'h44);
        chk({rx_timeout_count, rx_timeout_prescale}, 16'h5aa5);
        chk(backoff_random_seed, {7'h2b, 8'hc3});
        $display("field test done");
    endtask

    task automatic pkt(input logic [7:0] src, input logic [7:0] dst, input logic crc,
                       input logic exp);
        @(posedge sys_clk);
        pktCheck <= 1'b1;
        pktSource <= src;
        pktDest <= dst;
        crcOk <= crc;
        ackRequested <= 1'b1;
        @(posedge sys_clk);
        pktCheck <= 1'b0;
        @(negedge sys_clk);
        chk(pktDecided, 1'b1);
        chk(pktAccept, exp);
        chk(ackReply, exp);
    endtask

    task automatic t_filter;
        bus(pkt_filter_pkg::IDX_PROTO_CTRL, 1'b1, 8'h01);
        bus(pkt_filter_pkg::IDX_RETX_ACK, 1'b1, 8'h04);
        bus(pkt_filter_pkg::IDX_SRC_MASK, 1'b1, 8'hf0);
        bus(pkt_filter_pkg::IDX_GOAL3, 1'b1, 8'ha5);
        bus(pkt_filter_pkg::IDX_GOAL2, 1'b1, 8'hbc);
        bus(pkt_filter_pkg::IDX_GOAL1, 1'b1, 8'hcc);
        bus(pkt_filter_pkg::IDX_GOAL0, 1'b1, 8'h0e);
        bus(pkt_filter_pkg::IDX_FLT_OPT, 1'b1, 8'h11);
        pkt(8'ha3, 8'h00, 1'b1, 1'b1);
        pkt(8'h55, 8'h00, 1'b1, 1'b0);
        pkt(8'ha3, 8'h00, 1'b0, 1'b0);
        bus(pkt_filter_pkg::IDX_FLT_OPT, 1'b1, 8'h0e);
        pkt(8'h00, 8'hbc, 1'b0, 1'b1);
        pkt(8'h00, 8'hcc, 1'b0, 1'b1);
        pkt(8'h00, 8'h0e, 1'b0, 1'b1);
        pkt(8'h00, 8'h77, 1'b0, 1'b0);
        bus(pkt_filter_pkg::IDX_PROTO_CTRL, 1'b1, 8'h00);
        pkt(8'h00, 8'h77, 1'b0, 1'b1);
        bus(pkt_filter_pkg::IDX_PROTO_CTRL, 1'b1, 8'h01);
        bus(pkt_filter_pkg::IDX_FLT_OPT, 1'b1, 8'h10);
        bus(pkt_filter_pkg::IDX_PKT_CTRL, 1'b1, 8'h02);
        rxMode <= 1'b1;
        repeat (2) @(posedge sys_clk);
        pkt(8'h55, 8'h00, 1'b1, 1'b1);
        chk(dualSyncActive, 1'b1);
        chk(secondarySyncWord, 32'ha5bccc0e);
        chk(txDestAddr, 8'ha5);
        chk(txSourceAddr, 8'h0e);
        @(posedge sys_clk);
        rxMode <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(dualSyncActive, 1'b0);
        chk(secondarySyncWord, 32'h0);
        $display("filter test done");
    endtask

    task automatic t_timeout;
        for (int m = 0; m < 2; m++) begin
            bus(pkt_filter_pkg::IDX_FLT_OPT, 1'b1, {1'b0, m[0], 6'h00});
            for (int s = 0; s < 3; s++) begin
                carrierSense <= (s != 2);
                sync_quality_indicator <= (s == 1);
                preamble_quality_indicator <= (s == 1);
                @(posedge sys_clk);
                @(negedge sys_clk);
                chk(rxTimeoutStop, (s == 1) || (s == 0 && m == 1));
                @(posedge sys_clk);
            end
        end
        $display("timeout test done");
    endtask

    task automatic ev(input logic s, input logic r, input logic l, input logic [15:0] pc);
        @(posedge sys_clk);
        wakeupStart <= s;
        wakeupReloadReq <= r;
        @(posedge sys_clk);
        wakeupStart <= 1'b0;
        wakeupReloadReq <= 1'b0;
        @(negedge sys_clk);
        chk(wakeupLoad, l);
        chk({wakeupLoadPrescale, wakeupLoadCount}, pc);
    endtask

    task automatic t_wake;
        bus(pkt_filter_pkg::IDX_WU_PRE, 1'b1, 8'h12);
        bus(pkt_filter_pkg::IDX_WU_CNT, 1'b1, 8'h34);
        bus(pkt_filter_pkg::IDX_WU_RL_PRE, 1'b1, 8'h56);
        bus(pkt_filter_pkg::IDX_WU_RL_CNT, 1'b1, 8'h78);
        bus(pkt_filter_pkg::IDX_PROTO_CTRL, 1'b1, 8'h00);
        ev(1'b1, 1'b0, 1'b1, 16'h1234);
        ev(1'b0, 1'b1, 1'b0, 16'h1234);
        bus(pkt_filter_pkg::IDX_PROTO_CTRL, 1'b1, 8'h40);
        ev(1'b0, 1'b1, 1'b1, 16'h5678);
        ev(1'b1, 1'b0, 1'b1, 16'h1234);
        ev(1'b1, 1'b1, 1'b1, 16'h5678);
        $display("wake-up test done");
    endtask

    task automatic finishTest;
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {nrst, hsel, hwrite, rxMode, pktCheck, crcOk, ackRequested, carrierSense} = 8'h0;
        {wakeupStart, wakeupReloadReq, sync_quality_indicator, preamble_quality_indicator} = 4'h0;
        {haddr, htrans, hwdata, pktSource, pktDest} = '0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_fields();
        t_filter();
        t_timeout();
        t_wake();
        finishTest();
    end
endmodule

bind packet_protocol_filter_regs packet_protocol_filter_regs_asserts
    u_packet_protocol_filter_regs_asserts (.*);
